/* mis_alu.sv */
/*
  Combinational data path of the sequencer: transfer, arithmetic, logic,
  rotate and bit operations. Assumes operands are stable for a whole phase.
*/
`timescale 1ns/1ns
module mis_alu
  import mis_pkg::*;
(
  input  wire mis_op_t         op_i,
  input  wire logic [DW-1:0]   acc_i,
  input  wire logic [DW-1:0]   opnd_i,
  input  wire logic [DW-1:0]   imm_i,
  input  wire logic            carry_i,
  input  wire logic [2:0]      bit_i,
  output logic      [DW-1:0]   res_o,
  output logic                 carry_o,
  output logic                 upd_c_o,
  output logic                 upd_z_o
);

  always_comb
  begin
    logic [DW:0]   wide;
    logic [DW-1:0] mask;
    wide    = 9'h000;
    mask    = 8'h01 << bit_i;
    res_o   = opnd_i;
    carry_o = carry_i;
    upd_c_o = 1'b0;
    upd_z_o = 1'b0;
    case (op_i)
      OP_TRANSFER_M2A: res_o = opnd_i;
      OP_TRANSFER_A2M: res_o = acc_i;
      OP_TRANSFER_I2A: res_o = imm_i;
      OP_ADD, OP_ADD_IN_PLACE, OP_ADD_CARRY, OP_ADD_IMM:
      begin
        wide = {1'b0, acc_i}
             + {1'b0, (op_i == OP_ADD_IMM) ? imm_i : opnd_i}
             + {8'h00, (op_i == OP_ADD_CARRY) & carry_i};
        res_o   = wide[DW-1:0];
        carry_o = wide[DW];
        upd_c_o = 1'b1;
        upd_z_o = 1'b1;
      end
      OP_SUB, OP_SUB_IN_PLACE, OP_SUB_BORROW, OP_SUB_IMM:
      begin
        wide = {1'b0, acc_i}
             - {1'b0, (op_i == OP_SUB_IMM) ? imm_i : opnd_i}
             - {8'h00, (op_i == OP_SUB_BORROW) & carry_i};
        res_o   = wide[DW-1:0];
        carry_o = wide[DW];
        upd_c_o = 1'b1;
        upd_z_o = 1'b1;
      end
      OP_ADD_ONE_IN_PLACE, OP_ADD_ONE_TO_ACC:
      begin
        res_o   = opnd_i + 8'h01;
        upd_z_o = 1'b1;
      end
      OP_SUB_ONE_IN_PLACE, OP_SUB_ONE_TO_ACC:
      begin
        res_o   = opnd_i - 8'h01;
        upd_z_o = 1'b1;
      end
      OP_AND:
      begin
        res_o   = acc_i & opnd_i;
        upd_z_o = 1'b1;
      end
      OP_OR:
      begin
        res_o   = acc_i | opnd_i;
        upd_z_o = 1'b1;
      end
      OP_XOR:
      begin
        res_o   = acc_i ^ opnd_i;
        upd_z_o = 1'b1;
      end
      OP_INVERT_MEMORY:
      begin
        res_o   = ~opnd_i;
        upd_z_o = 1'b1;
      end
      OP_ROTATE_RIGHT_PLAIN: res_o = {opnd_i[0], opnd_i[DW-1:1]};
      OP_ROTATE_LEFT_PLAIN:  res_o = {opnd_i[DW-2:0], opnd_i[DW-1]};
      OP_ROTATE_RIGHT_THRU_CARRY:
      begin
        res_o   = {carry_i, opnd_i[DW-1:1]};
        carry_o = opnd_i[0];
        upd_c_o = 1'b1;
      end
      OP_ROTATE_LEFT_THRU_CARRY:
      begin
        res_o   = {opnd_i[DW-2:0], carry_i};
        carry_o = opnd_i[DW-1];
        upd_c_o = 1'b1;
      end
      OP_BIT_FORCE_HIGH: res_o = opnd_i | mask;
      OP_BIT_FORCE_LOW:  res_o = opnd_i & ~mask;
      OP_MISC:           res_o = imm_i;
      default:           res_o = opnd_i;
    endcase
  end

endmodule : mis_alu

/* mis_core.sv */
/*
  Instruction sequencer core: four-phase instruction cycle, one-deep
  fetch pipeline, flags, return stack, halt and wake.
  Assumes program and data memory answer combinationally within a phase.
*/
`timescale 1ns/1ns
module mis_core
  import mis_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  output logic      [PC_W-1:0] pm_addr_o,
  input  wire logic [IW-1:0]   pm_data_i,
  output logic      [DW-1:0]   dm_addr_o,
  input  wire logic [DW-1:0]   dm_rdata_i,
  output logic      [DW-1:0]   dm_wdata_o,
  output logic                 dm_we_o,
  input  wire logic            wake_i,
  output logic                 halted_o,
  output logic                 wdt_clear_o,
  output logic                 cycle_end_o,
  output logic                 idle_cycle_o,
  output logic      [DW-1:0]   acc_o,
  output logic                 carry_o,
  output logic                 zero_o
);

  //****************************************************************
  // State
  //****************************************************************
  mis_phase_t      phase_q, phase_d;
  logic [IW-1:0]   ir_q, ir_d;
  logic            irv_q, irv_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [DW-1:0]   acc_q, acc_d;
  logic            c_q, c_d;
  logic            z_q, z_d;
  logic [DW-1:0]   opnd_q, opnd_d;
  logic [DW-1:0]   res_q, res_d;
  logic            resc_q, resc_d;
  logic [DW-1:0]   tbl_q, tbl_d;
  logic            halted_q, halted_d;
  logic            wdt_q, wdt_d;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [PC_W-1:0] stack_d [STACK_DEPTH];
  logic [SP_W-1:0] sp_q, sp_d;
  logic            wake_s1_q, wake_s2_q, wake_s3_q;

  //****************************************************************
  // Decode
  //****************************************************************
  mis_op_t         op;
  logic [2:0]      sub;
  logic [DW-1:0]   arg;
  logic [PC_W-1:0] tgt;
  logic [PC_W-1:0] stack_top;
  logic            is_tbl;
  logic            pc_lo_hit;
  logic            mem_wr;
  logic            pc_lo_wr;
  logic            skip_take;
  logic            is_exit;
  logic            flush;
  logic            commit;
  logic [DW-1:0]   dm_rd;
  logic [DW-1:0]   alu_res;
  logic            alu_c;
  logic            upd_c;
  logic            upd_z;

  assign op        = mis_op_t'(ir_q[OP_HI:OP_LO]);
  assign sub       = ir_q[SUB_HI:SUB_LO];
  assign arg       = ir_q[ARG_HI:ARG_LO];
  assign tgt       = ir_q[PC_W-1:0];
  assign stack_top = stack_q[sp_q - SP_W'(1)];
  assign is_tbl    = (op == OP_MISC) && (sub == MISC_TBL);
  assign is_exit   = op inside {OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT};
  assign pc_lo_hit = (arg == PC_LO_ADDR);
  assign mem_wr    = irv_q && op_writes_mem(ir_q);
  assign commit    = (phase_q == PH_Q4) && !halted_q && irv_q;
  assign dm_rd     = pc_lo_hit ? pc_q[DW-1:0] : dm_rdata_i;

  assign pc_lo_wr  = mem_wr && pc_lo_hit;

  assign skip_take = ((op == OP_SKIP_ZERO) && (opnd_q == 8'h00))
                  || ((op == OP_SKIP_BIT_HIGH) && opnd_q[sub]);

  assign flush = irv_q && (op inside {OP_GOTO, OP_CALL} || is_exit || is_tbl
                           || skip_take || pc_lo_wr);

  mis_alu u_alu (
    .op_i    (op),
    .acc_i   (acc_q),
    .opnd_i  (opnd_q),
    .imm_i   (is_tbl ? tbl_q : arg),
    .carry_i (c_q),
    .bit_i   (sub),
    .res_o   (alu_res),
    .carry_o (alu_c),
    .upd_c_o (upd_c),
    .upd_z_o (upd_z)
  );

  //****************************************************************
  // Next state
  //****************************************************************
  always_comb
  begin
    phase_d  = phase_q;
    ir_d     = ir_q;
    irv_d    = irv_q;
    pc_d     = pc_q;
    acc_d    = acc_q;
    c_d      = c_q;
    z_d      = z_q;
    opnd_d   = opnd_q;
    res_d    = res_q;
    resc_d   = resc_q;
    tbl_d    = tbl_q;
    halted_d = halted_q;
    wdt_d    = 1'b0;
    stack_d  = stack_q;
    sp_d     = sp_q;
    if (halted_q && wake_s2_q && !wake_s3_q)
      halted_d = 1'b0;
    if (!halted_q)
    begin
      unique case (phase_q)
        PH_Q1: phase_d = PH_Q2;
        PH_Q2:
        begin
          phase_d = PH_Q3;
          opnd_d  = dm_rd;
          tbl_d   = pm_data_i[DW-1:0];
        end
        PH_Q3:
        begin
          phase_d = PH_Q4;
          res_d   = alu_res;
          resc_d  = alu_c;
        end
        PH_Q4:   phase_d = PH_Q1;
        default: phase_d = PH_Q1;
      endcase
    end
    if (commit)
    begin
      if (op_writes_acc(ir_q))
        acc_d = res_q;
      if (upd_c)
        c_d = resc_q;
      if (upd_z)
        z_d = (res_q == 8'h00);
      if (op == OP_CALL)
      begin
        stack_d[sp_q] = pc_q;
        sp_d          = sp_q + SP_W'(1);
      end
      if (is_exit)
        sp_d = sp_q - SP_W'(1);
      if (op == OP_MISC && sub == MISC_HALT)
        halted_d = 1'b1;
      if (op == OP_MISC && sub == MISC_WDT)
        wdt_d = 1'b1;
    end
    if ((phase_q == PH_Q4) && !halted_q)
    begin
      if (flush)
      begin
        irv_d = 1'b0;
        if (op inside {OP_GOTO, OP_CALL})
          pc_d = tgt;
        else if (is_exit)
          pc_d = stack_top;
        else if (skip_take)
          pc_d = pc_q + PC_W'(1);
        else if (pc_lo_wr)
          pc_d = {pc_q[PC_W-1:DW], res_q};
      end
      else
      begin
        irv_d = 1'b1;
        ir_d  = pm_data_i;
        pc_d  = pc_q + PC_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      phase_q   <= PH_Q1;
      ir_q      <= 16'h0000;
      irv_q     <= 1'b0;
      pc_q      <= PC_RST;
      acc_q     <= ACC_RST;
      c_q       <= 1'b0;
      z_q       <= 1'b0;
      opnd_q    <= 8'h00;
      res_q     <= 8'h00;
      resc_q    <= 1'b0;
      tbl_q     <= 8'h00;
      halted_q  <= 1'b0;
      wdt_q     <= 1'b0;
      sp_q      <= 2'h0;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_q[i] <= PC_RST;
    end
    else
    begin
      phase_q   <= phase_d;
      ir_q      <= ir_d;
      irv_q     <= irv_d;
      pc_q      <= pc_d;
      acc_q     <= acc_d;
      c_q       <= c_d;
      z_q       <= z_d;
      opnd_q    <= opnd_d;
      res_q     <= res_d;
      resc_q    <= resc_d;
      tbl_q     <= tbl_d;
      halted_q  <= halted_d;
      wdt_q     <= wdt_d;
      sp_q      <= sp_d;
      wake_s1_q <= wake_i;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
      stack_q   <= stack_d;
    end
  end

  //****************************************************************
  // Outputs
  //****************************************************************
  assign pm_addr_o    = ((phase_q == PH_Q2) && irv_q && is_tbl) ? {3'h0, acc_q} : pc_q;
  assign dm_addr_o    = arg;
  assign dm_wdata_o   = res_q;
  assign dm_we_o      = (phase_q == PH_Q4) && !halted_q && mem_wr && !pc_lo_hit;
  assign halted_o     = halted_q;
  assign wdt_clear_o  = wdt_q;
  assign cycle_end_o  = (phase_q == PH_Q4) && !halted_q;
  assign idle_cycle_o = !irv_q;
  assign acc_o        = acc_q;
  assign carry_o      = c_q;
  assign zero_o       = z_q;

  //****************************************************************
  // Assertions
  //****************************************************************
  AST_CYCLE_FOUR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase_q == PH_Q1 && !halted_q) |=> phase_q == PH_Q2 ##1 phase_q == PH_Q3
      ##1 phase_q == PH_Q4 ##1 phase_q == PH_Q1)
    else $error("instruction cycle is not four clocks");

  AST_ORDINARY_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op inside {OP_TRANSFER_M2A, OP_ADD, OP_AND, OP_ADD_ONE_TO_ACC})
      |=> irv_q)
    else $error("ordinary instruction took an extra cycle");

  AST_GOTO_TWO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op == OP_GOTO) |=> (!irv_q && pc_q == $past(tgt)
      && sp_q == $past(sp_q)) ##4 irv_q)
    else $error("goto did not jump in two cycles");

  AST_CALL_SAVE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op == OP_CALL) |=> stack_top == $past(pc_q) && !irv_q)
    else $error("call did not save next address");

  AST_EXIT_RESUME: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && is_exit) |=> pc_q == $past(stack_top) && !irv_q)
    else $error("exit did not resume at saved address");

  AST_PC_LO_JUMP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && pc_lo_wr) |-> !dm_we_o ##1 (!irv_q && pc_q[DW-1:0] == $past(res_q)))
    else $error("low byte write did not jump");

  AST_SKIP_TAKEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && skip_take) |=> (!irv_q && pc_q == $past(pc_q) + 11'h001) ##4 irv_q)
    else $error("taken skip not two cycles");

  AST_SKIP_NOT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op inside {OP_SKIP_ZERO, OP_SKIP_BIT_HIGH} && !skip_take) |=> irv_q)
    else $error("untaken skip lost next instruction");

  AST_CARRY_ADD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op == OP_ADD) |=>
      c_q == (({1'b0, $past(acc_q)} + {1'b0, $past(opnd_q)}) > 9'h0ff))
    else $error("add carry wrong");

  AST_ZERO_LOGIC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op inside {OP_AND, OP_OR, OP_XOR}) |=> z_q == (acc_q == 8'h00))
    else $error("logic zero flag wrong");

  AST_INC_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op == OP_ADD_ONE_TO_ACC) |=> acc_q == $past(opnd_q) + 8'h01)
    else $error("increment not by one");

  AST_ROTATE_CARRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (dm_we_o && op == OP_ROTATE_RIGHT_THRU_CARRY)
      |-> dm_wdata_o == {c_q, opnd_q[DW-1:1]} ##1 c_q == $past(opnd_q[0]))
    else $error("rotate through carry wrong");

  AST_BIT_ONLY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (dm_we_o && op inside {OP_BIT_FORCE_HIGH, OP_BIT_FORCE_LOW})
      |-> ((dm_wdata_o ^ opnd_q) & ~(8'h01 << sub)) == 8'h00
        && dm_wdata_o[sub] == (op == OP_BIT_FORCE_HIGH))
    else $error("bit force touched other bits");

  AST_TABLE_DATA: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (dm_we_o && is_tbl) |-> dm_wdata_o == tbl_q ##1 !irv_q)
    else $error("table read data or timing wrong");

  AST_HALT_STOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && op == OP_MISC && sub == MISC_HALT) |=> halted_q && phase_q == PH_Q1)
    else $error("halt did not stop execution");

endmodule : mis_core

/* mis_mem_model.sv */
/*
  Behavioural program and data memory facing the sequencer core.
  Assumes the bench loads both arrays while the core is held in reset.
*/
`timescale 1ns/1ns
module mis_mem_model
  import mis_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic [PC_W-1:0] pm_addr_i,
  output logic      [IW-1:0]   pm_data_o,
  input  wire logic [DW-1:0]   dm_addr_i,
  output logic      [DW-1:0]   dm_rdata_o,
  input  wire logic [DW-1:0]   dm_wdata_i,
  input  wire logic            dm_we_i
);
  logic [IW-1:0] pm [2**PC_W];
  logic [DW-1:0] dm [2**DW];

  // Combinational reads, as the core expects
  assign pm_data_o  = pm[pm_addr_i];
  assign dm_rdata_o = dm[dm_addr_i];

  always @(posedge ref_clk_i)
  begin
    if (dm_we_i === 1'b1)
    begin
      dm[dm_addr_i] <= dm_wdata_i;
    end
  end
endmodule : mis_mem_model

/* mis_pkg.sv */
/*
  Shared constants, types and decode functions for the instruction sequencer.
  Assumes one 50 MHz clock and a synchronous active-high reset.
*/
// Function
// - Ordinary instructions finish in one cycle
// - Branch, call, exits, table read: two
// - One instruction cycle is four clocks
// - Program counter low write jumps, extra cycle
// - Taken skip costs one extra cycle
// - Three transfer forms through the accumulator
// - Carry above 255, borrow below zero
// - Increment or decrement by exactly one
// - Logic results of zero set zero flag
// - Logic operands pass through the accumulator
// - Rotate one bit, carry variants chain carry
// - Call saves next address, exit resumes there
// - Goto loads target, saves nothing
// - Conditional test skips or runs next
// - Bit force changes only chosen bit
// - Table read moves program constant to data
// - Power-down halts, watchdog clear provided
package mis_pkg;

  localparam int IW          = 16;
  localparam int PC_W        = 11;
  localparam int DW          = 8;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W        = 2;
  localparam int PHASES      = 4;

  // Instruction word fields
  localparam int OP_HI  = 15;
  localparam int OP_LO  = 11;
  localparam int SUB_HI = 10;
  localparam int SUB_LO = 8;
  localparam int ARG_HI = 7;
  localparam int ARG_LO = 0;

  // Program counter low byte mapped into data space
  localparam logic [DW-1:0]   PC_LO_ADDR = 8'h02;
  localparam logic [PC_W-1:0] PC_RST     = 11'h000;
  localparam logic [DW-1:0]   ACC_RST    = 8'h00;

  localparam logic [2:0] MISC_NOP  = 3'h0;
  localparam logic [2:0] MISC_HALT = 3'h1;
  localparam logic [2:0] MISC_WDT  = 3'h2;
  localparam logic [2:0] MISC_TBL  = 3'h3;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } mis_phase_t;

  typedef enum logic [4:0] {
    OP_MISC                 = 5'h00,
    OP_TRANSFER_M2A         = 5'h01,
    OP_TRANSFER_A2M         = 5'h02,
    OP_TRANSFER_I2A         = 5'h03,
    OP_ADD                  = 5'h04,
    OP_ADD_IN_PLACE         = 5'h05,
    OP_ADD_CARRY            = 5'h06,
    OP_ADD_IMM              = 5'h07,
    OP_SUB                  = 5'h08,
    OP_SUB_IN_PLACE         = 5'h09,
    OP_SUB_BORROW           = 5'h0A,
    OP_SUB_IMM              = 5'h0B,
    OP_ADD_ONE_IN_PLACE     = 5'h0C,
    OP_ADD_ONE_TO_ACC       = 5'h0D,
    OP_SUB_ONE_IN_PLACE     = 5'h0E,
    OP_SUB_ONE_TO_ACC       = 5'h0F,
    OP_AND                  = 5'h10,
    OP_OR                   = 5'h11,
    OP_XOR                  = 5'h12,
    OP_INVERT_MEMORY        = 5'h13,
    OP_ROTATE_RIGHT_PLAIN   = 5'h14,
    OP_ROTATE_LEFT_PLAIN    = 5'h15,
    OP_ROTATE_RIGHT_THRU_CARRY = 5'h16,
    OP_ROTATE_LEFT_THRU_CARRY  = 5'h17,
    OP_GOTO                 = 5'h18,
    OP_CALL                 = 5'h19,
    OP_SUBROUTINE_EXIT      = 5'h1A,
    OP_INTERRUPT_EXIT       = 5'h1B,
    OP_SKIP_ZERO            = 5'h1C,
    OP_SKIP_BIT_HIGH        = 5'h1D,
    OP_BIT_FORCE_HIGH       = 5'h1E,
    OP_BIT_FORCE_LOW        = 5'h1F
  } mis_op_t;

  function automatic logic op_writes_mem(input logic [IW-1:0] ir);
    mis_op_t op;
    op = mis_op_t'(ir[OP_HI:OP_LO]);
    return (op inside {OP_TRANSFER_A2M, OP_ADD_IN_PLACE, OP_SUB_IN_PLACE,
                       OP_ADD_ONE_IN_PLACE, OP_SUB_ONE_IN_PLACE, OP_INVERT_MEMORY,
                       OP_ROTATE_RIGHT_PLAIN, OP_ROTATE_LEFT_PLAIN,
                       OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY,
                       OP_BIT_FORCE_HIGH, OP_BIT_FORCE_LOW})
        || (op == OP_MISC && ir[SUB_HI:SUB_LO] == MISC_TBL);
  endfunction : op_writes_mem

  function automatic logic op_writes_acc(input logic [IW-1:0] ir);
    mis_op_t op;
    op = mis_op_t'(ir[OP_HI:OP_LO]);
    return op inside {OP_TRANSFER_M2A, OP_TRANSFER_I2A, OP_ADD, OP_ADD_CARRY,
                      OP_ADD_IMM, OP_SUB, OP_SUB_BORROW, OP_SUB_IMM,
                      OP_ADD_ONE_TO_ACC, OP_SUB_ONE_TO_ACC, OP_AND, OP_OR, OP_XOR};
  endfunction : op_writes_acc

endpackage : mis_pkg

/* mis_tb.sv */
/*
  Self-checking bench for the sequencer: programs run from the memory model.
  Assumes one 50 MHz clock; each data write is checked with its cycle number.
*/
`timescale 1ns/1ns
module testbench
  import mis_pkg::*;
;
  typedef struct {
    int         cyc;
    logic [7:0] addr;
    logic [7:0] data;
    logic       c;
    logic       z;
    logic [1:0] chk;
  } mis_exp_t;

  logic            ref_clk_i = 1'b0;
  logic            rst_i     = 1'b1;
  logic            wake_i    = 1'b0;
  logic [PC_W-1:0] pm_addr;
  logic [IW-1:0]   pm_data;
  logic [DW-1:0]   dm_addr, dm_rdata, dm_wdata, acc;
  logic            dm_we, halted, wdt_clear, cyc_end, idle, carry, zero;
  mis_exp_t        exp_q[$];
  int              err_count = 0, checks_done = 0, cyc_cnt = 0, wdt_seen = 0, idl_cnt = 0, n;
  logic [7:0]      a, b, x, r, s, v;
  logic [8:0]      t9;
  logic [2:0]      k, j;

  mis_core uut (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .pm_addr_o    (pm_addr),
    .pm_data_i    (pm_data),
    .dm_addr_o    (dm_addr),
    .dm_rdata_i   (dm_rdata),
    .dm_wdata_o   (dm_wdata),
    .dm_we_o      (dm_we),
    .wake_i       (wake_i),
    .halted_o     (halted),
    .wdt_clear_o  (wdt_clear),
    .cycle_end_o  (cyc_end),
    .idle_cycle_o (idle),
    .acc_o        (acc),
    .carry_o      (carry),
    .zero_o       (zero)
  );

  mis_mem_model mem (
    .ref_clk_i  (ref_clk_i),
    .pm_addr_i  (pm_addr),
    .pm_data_o  (pm_data),
    .dm_addr_i  (dm_addr),
    .dm_rdata_o (dm_rdata),
    .dm_wdata_i (dm_wdata),
    .dm_we_i    (dm_we)
  );

  initial
  begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic p(int ad, mis_op_t op, logic [2:0] sb, logic [7:0] ag);
    mem.pm[ad] = {op, sb, ag};
  endtask : p

  task automatic ew(int cy, logic [7:0] ad, logic [7:0] dt, logic c, logic z,
                    logic [1:0] ck);
    exp_q.push_back('{cy, ad, dt, c, z, ck});
  endtask : ew

  task automatic bad(string m);
    err_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : bad

  task automatic cmp_wr(mis_exp_t e);
    checks_done++;
    if (cyc_cnt != e.cyc || dm_addr !== e.addr || dm_wdata !== e.data
        || (e.chk[1] && carry !== e.c) || (e.chk[0] && zero !== e.z))
      bad($sformatf("write cyc %0d adr %h dat %h c %b z %b", cyc_cnt, dm_addr,
                    dm_wdata, carry, zero));
  endtask : cmp_wr

  task automatic cmp_bit(logic got, logic want, string m);
    checks_done++;
    if (got !== want)
      bad(m);
  endtask : cmp_bit

  task automatic rst_on();
    @(negedge ref_clk_i);
    rst_i <= 1'b1;
    for (int i = 0; i < 2048; i++)
      mem.pm[i] = '0;
    for (int i = 0; i < 256; i++)
      mem.dm[i] = '0;
  endtask : rst_on

  task automatic rst_off();
    repeat (12) @(negedge ref_clk_i);
    rst_i <= 1'b0;
  endtask : rst_off

  task automatic fin(string nm);
    for (int i = 0; i < 300 && exp_q.size() > 0; i++)
      @(negedge ref_clk_i);
    repeat (20) @(negedge ref_clk_i);
    if (exp_q.size() > 0)
      bad("write missing");
    $display("test %s done", nm);
  endtask : fin

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // ****************************************
  // Watchers
  // ****************************************
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
      cyc_cnt <= 0;
    else if (cyc_end === 1'b1)
      cyc_cnt <= cyc_cnt + 1;
    if (rst_i)
      wdt_seen <= 0;
    else if (wdt_clear === 1'b1)
      wdt_seen <= wdt_seen + 1;
    if (rst_i)
      idl_cnt <= 0;
    else if (cyc_end === 1'b1 && idle === 1'b1)
      idl_cnt <= idl_cnt + 1;
  end

  always @(negedge ref_clk_i)
  begin
    if (!rst_i && dm_we === 1'b1)
    begin
      if (exp_q.size() == 0)
        bad("write not expected");
      else
        cmp_wr(exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    end_of_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    void'($urandom(32'hfe67_0e01));
    a = 8'($urandom());
    b = 8'($urandom());
    x = 8'($urandom());
    r = 8'($urandom());
    s = 8'($urandom());
    v = 8'($urandom());
    k = 3'($urandom());
    j = 3'($urandom());
    // Transfer and arithmetic
    rst_on();
    mem.dm[8'h20] = b;
    mem.dm[8'h21] = 8'hff;
    t9 = {1'b0, a} + b;
    p(0, OP_TRANSFER_I2A, 0, a);
    p(1, OP_TRANSFER_A2M, 0, 8'h10);
    ew(2, 8'h10, a, 0, 0, 3);
    p(2, OP_ADD, 0, 8'h20);
    p(3, OP_TRANSFER_A2M, 0, 8'h11);
    ew(4, 8'h11, t9[7:0], t9[8], t9[7:0] == 0, 3);
    p(4, OP_SUB_IMM, 0, x);
    p(5, OP_TRANSFER_A2M, 0, 8'h12);
    ew(6, 8'h12, t9[7:0] - x, t9[7:0] < x, t9[7:0] == x, 3);
    p(6, OP_ADD_ONE_IN_PLACE, 0, 8'h21);
    ew(7, 8'h21, 8'h00, t9[7:0] < x, t9[7:0] == x, 3);
    p(7, OP_SUB_ONE_IN_PLACE, 0, 8'h22);
    ew(8, 8'h22, 8'hff, 0, 1, 1);
    p(8, OP_ADD_ONE_TO_ACC, 0, 8'h20);
    p(9, OP_TRANSFER_A2M, 0, 8'h13);
    ew(10, 8'h13, b + 8'h01, 0, b == 8'hff, 1);
    p(10, OP_SUB_ONE_TO_ACC, 0, 8'h20);
    p(11, OP_TRANSFER_A2M, 0, 8'h14);
    ew(12, 8'h14, b - 8'h01, 0, b == 8'h01, 1);
    p(12, OP_TRANSFER_I2A, 0, 8'h05);
    p(13, OP_SUB, 0, 8'h22);
    p(14, OP_SUB_BORROW, 0, 8'h21);
    p(15, OP_ADD_IN_PLACE, 0, 8'h22);
    ew(16, 8'h22, 8'h04, 0, 0, 3);
    p(16, OP_ADD_CARRY, 0, 8'h22);
    p(17, OP_SUB_IN_PLACE, 0, 8'h21);
    ew(18, 8'h21, 8'h0a, 0, 0, 3);
    p(18, OP_TRANSFER_M2A, 0, 8'h22);
    p(19, OP_TRANSFER_A2M, 0, 8'h11);
    ew(20, 8'h11, 8'h04, 0, 0, 3);
    rst_off();
    fin("arith");
    cmp_bit(acc === 8'h04, 1'b1, "accumulator");
    cmp_bit(idl_cnt == 1, 1'b1, "idle cycles");
    // Logic, rotate and bit operations
    rst_on();
    mem.dm[8'h20] = b;
    mem.dm[8'h21] = a & b;
    mem.dm[8'h22] = r;
    mem.dm[8'h23] = s;
    mem.dm[8'h24] = r;
    p(0, OP_TRANSFER_I2A, 0, a);
    p(1, OP_AND, 0, 8'h20);
    p(2, OP_TRANSFER_A2M, 0, 8'h10);
    ew(3, 8'h10, a & b, 0, (a & b) == 0, 1);
    p(3, OP_XOR, 0, 8'h21);
    p(4, OP_TRANSFER_A2M, 0, 8'h11);
    ew(5, 8'h11, 8'h00, 0, 1, 1);
    p(5, OP_OR, 0, 8'h20);
    p(6, OP_TRANSFER_A2M, 0, 8'h12);
    ew(7, 8'h12, b, 0, b == 0, 1);
    p(7, OP_INVERT_MEMORY, 0, 8'h20);
    ew(8, 8'h20, ~b, 0, b == 0, 1);
    p(8, OP_TRANSFER_I2A, 0, 8'hff);
    p(9, OP_ADD_IMM, 0, 8'h01);
    p(10, OP_ROTATE_LEFT_THRU_CARRY, 0, 8'h22);
    ew(11, 8'h22, {r[6:0], 1'b1}, 1, 1, 3);
    p(11, OP_ROTATE_RIGHT_THRU_CARRY, 0, 8'h22);
    ew(12, 8'h22, r, r[7], 1, 3);
    p(12, OP_ROTATE_RIGHT_PLAIN, 0, 8'h24);
    ew(13, 8'h24, {r[0], r[7:1]}, 1, 1, 3);
    p(13, OP_ROTATE_LEFT_PLAIN, 0, 8'h23);
    ew(14, 8'h23, {s[6:0], s[7]}, 0, 1, 1);
    p(14, OP_BIT_FORCE_LOW, k, 8'h23);
    ew(15, 8'h23, {s[6:0], s[7]} & ~(8'h01 << k), 0, 1, 1);
    p(15, OP_BIT_FORCE_HIGH, j, 8'h22);
    ew(16, 8'h22, r | (8'h01 << j), 0, 0, 0);
    rst_off();
    fin("logic");
    // Branches, skips, table read, counter write, halt
    rst_on();
    mem.dm[8'h33] = s | (8'h01 << k);
    mem.pm[40] = {s, r};
    for (int i = 1; i < 16; i++)
      p(i, OP_TRANSFER_A2M, 0, 8'h30);
    p(0, OP_GOTO, 0, 8'h03);
    p(3, OP_CALL, 0, 8'h14);
    p(20, OP_TRANSFER_I2A, 0, v);
    p(21, OP_INTERRUPT_EXIT, 0, 8'h00);
    p(4, OP_TRANSFER_A2M, 0, 8'h31);
    ew(8, 8'h31, v, 0, 0, 0);
    p(5, OP_SKIP_ZERO, 0, 8'h32);
    p(7, OP_SKIP_ZERO, 0, 8'h33);
    p(8, OP_TRANSFER_A2M, 0, 8'h34);
    ew(12, 8'h34, v, 0, 0, 0);
    p(9, OP_SKIP_BIT_HIGH, k, 8'h33);
    p(11, OP_CALL, 0, 8'h16);
    p(22, OP_TRANSFER_I2A, 0, 8'h28);
    p(23, OP_MISC, MISC_TBL, 8'h35);
    ew(18, 8'h35, r, 0, 0, 0);
    p(24, OP_SUBROUTINE_EXIT, 0, 8'h00);
    p(12, OP_TRANSFER_I2A, 0, 8'h10);
    p(13, OP_TRANSFER_A2M, 0, 8'h02);
    p(16, OP_MISC, MISC_WDT, 8'h00);
    p(17, OP_MISC, MISC_HALT, 8'h00);
    p(18, OP_TRANSFER_A2M, 0, 8'h36);
    ew(27, 8'h36, 8'h10, 0, 0, 0);
    rst_off();
    for (int i = 0; i < 400 && halted !== 1'b1; i++)
      @(negedge ref_clk_i);
    n = cyc_cnt;
    repeat (40) @(negedge ref_clk_i);
    cmp_bit(halted, 1'b1, "not halted");
    cmp_bit(cyc_cnt == n, 1'b1, "cycles ran while halted");
    cmp_bit(wdt_seen == 1, 1'b1, "watchdog clear count");
    cmp_bit(idl_cnt == 10, 1'b1, "idle cycles");
    wake_i <= 1'b1;
    fin("branch");
    wake_i <= 1'b0;
    end_of_test();
  end
endmodule : testbench
